// ===== fcs_tx.sv
/*
 Sending end: flags, bit stuffing, CRC generation, abort and gap timing.
 Assumes the user holds a byte on TX_DATA until TX_READY takes it.
*/
`timescale 1ns/100ps
module fcs_tx (
	input  wire logic  CLK,
	input  wire logic  RST_N,
	input  wire logic  TX_START,     // Begin frame, level while queued
	input  wire logic  TX_NEW_DIALOGUE, // Frame opens a new dialogue
	input  wire logic [3:0] TX_DEFER_SLOTS, // Extra dialogue deferral slots
	input  wire logic  TX_VALID,     // Byte available
	input  wire logic [7:0] TX_DATA, // Byte to send
	input  wire logic  TX_LAST,      // Byte is last of frame
	input  wire logic  TX_ABORT,     // Abort current frame
	output logic       TX_READY,     // Byte was taken at the previous clock edge
	output logic       TX_BUSY,      // Frame in progress
	output logic       TX_GAP_LATE,  // Inter-frame gap exceeded
	output logic       TX_TOO_LONG,  // Data overran the limit, aborted
	fcs_link_if.tx_end link
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_WAIT  = 3'h1,
		S_FLAG  = 3'h2,
		S_DATA  = 3'h3,
		S_FCS   = 3'h4,
		S_CLOSE = 3'h5,
		S_ABORT = 3'h6
	} tx_state_e;

	tx_state_e   state_r, state_nxt;   // Sequencer state
	logic [7:0]  sh_r, sh_nxt;         // Byte shifter
	logic [3:0]  bit_r, bit_nxt;       // Bit index in byte or abort ones
	logic [1:0]  flags_r, flags_nxt;   // Opening flags sent
	logic [15:0] crc_r, crc_nxt;       // CRC accumulator
	logic [15:0] fcs_r, fcs_nxt;       // Inverted remainder shifter
	logic [2:0]  ones_r, ones_nxt;     // Run of ones for stuffing
	logic [9:0]  cnt_r, cnt_nxt;       // Data byte count
	logic        last_r, last_nxt;     // Current byte is last
	logic [19:0] gap_r, gap_nxt;       // Idle cycles since frame end
	logic        ready_r, ready_nxt;
	logic        late_r, late_nxt;
	logic        long_r, long_nxt;
	logic        bit_o_r, bit_o_nxt;
	logic        val_r, val_nxt;
	logic        drv_r, drv_nxt;
	logic        busy_r, busy_nxt;     // Frame on the line, registered

	assign TX_READY = ready_r;
	assign TX_BUSY = busy_r;
	assign TX_GAP_LATE = late_r;
	assign TX_TOO_LONG = long_r;
	assign link.bit_data = bit_o_r;
	assign link.bit_valid = val_r;
	assign link.drive_en = drv_r;

	// Next-state logic for the whole sender
	always_comb begin
		logic [19:0] need;
		logic        b;
		logic        stuff;
		need = 20'(fcs_pkg::IDG_CYC) + 20'(TX_DEFER_SLOTS) * 20'(fcs_pkg::SLOT_CYC); // [R17] [R18]
		b = 1'b0;
		stuff = 1'b0;
		state_nxt = state_r;
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		flags_nxt = flags_r;
		crc_nxt = crc_r;
		fcs_nxt = fcs_r;
		ones_nxt = ones_r;
		cnt_nxt = cnt_r;
		last_nxt = last_r;
		gap_nxt = (gap_r == 20'hfffff) ? gap_r : gap_r + 20'h00001;
		ready_nxt = 1'b0;
		late_nxt = late_r;
		long_nxt = long_r;
		bit_o_nxt = 1'b1;
		val_nxt = 1'b0;
		drv_nxt = 1'b0;
		case (state_r)
			S_IDLE: begin
				if (TX_START) begin
					state_nxt = S_WAIT;
					late_nxt = !TX_NEW_DIALOGUE && (gap_r >= 20'(fcs_pkg::IFG_CYC)); // [R16]
				end
			end
			S_WAIT: begin
				// New dialogues wait out the gap; follow-on frames go at once
				if (!TX_NEW_DIALOGUE || gap_r >= need) begin
					state_nxt = S_FLAG;
					sh_nxt = fcs_pkg::FLAG_BYTE;                 // [R12]
					bit_nxt = 4'h0;
					flags_nxt = 2'h0;
					crc_nxt = fcs_pkg::CRC_PRESET;               // [R3]
					cnt_nxt = 10'h000;
					long_nxt = 1'b0;
				end
			end
			S_FLAG: begin
				val_nxt = 1'b1;
				drv_nxt = 1'b1;
				bit_o_nxt = sh_r[7];
				sh_nxt = {sh_r[6:0], 1'b0};
				bit_nxt = bit_r + 4'h1;
				// Track the line run so an abort tops it up to exact length
				ones_nxt = bit_o_nxt ? ones_r + 3'h1 : 3'h0;
				if (bit_r == 4'h7) begin
					bit_nxt = 4'h0;
					flags_nxt = flags_r + 2'h1;
					sh_nxt = fcs_pkg::FLAG_BYTE;
					if (flags_r == 2'(fcs_pkg::OPEN_FLAGS - 1) && TX_VALID) begin // [R13]
						state_nxt = S_DATA;
						sh_nxt = TX_DATA;
						last_nxt = TX_LAST;
						ready_nxt = 1'b1;
						cnt_nxt = 10'h001;
					end else if (flags_r == 2'(fcs_pkg::OPEN_FLAGS - 1)) begin
						flags_nxt = flags_r;  // Keep flagging until data arrives
					end
				end
			end
			S_DATA: begin
				val_nxt = 1'b1;
				drv_nxt = 1'b1;
				stuff = (ones_r == 3'h5);
				if (stuff) begin
					bit_o_nxt = 1'b0;                            // Stuffed bit, CRC skips it [R19]
					ones_nxt = 3'h0;
				end else begin
					b = sh_r[0];
					bit_o_nxt = b;
					ones_nxt = b ? ones_r + 3'h1 : 3'h0;
					crc_nxt = fcs_pkg::crc_step(crc_r, b);       // [R2] [R19]
					sh_nxt = {1'b0, sh_r[7:1]};
					bit_nxt = bit_r + 4'h1;
					if (bit_r == 4'h7) begin
						bit_nxt = 4'h0;
						if (last_r) begin
							state_nxt = S_FCS;
							fcs_nxt = ~fcs_pkg::crc_step(crc_r, b);  // [R4]
						end else if (TX_VALID) begin
							sh_nxt = TX_DATA;
							last_nxt = TX_LAST;
							ready_nxt = 1'b1;
							cnt_nxt = cnt_r + 10'h001;
							// Header bytes are not part of the data limit
							if (cnt_r == 10'(fcs_pkg::MAX_DATA + 3)) begin // [R15]
								long_nxt = 1'b1;
								state_nxt = S_ABORT;
							end
						end else begin
							state_nxt = S_ABORT;  // Underrun mid-frame
						end
					end
				end
			end
			S_FCS: begin
				val_nxt = 1'b1;
				drv_nxt = 1'b1;
				stuff = (ones_r == 3'h5);
				if (stuff) begin
					bit_o_nxt = 1'b0;
					ones_nxt = 3'h0;
				end else begin
					b = fcs_r[15];                               // [R5]
					bit_o_nxt = b;
					ones_nxt = b ? ones_r + 3'h1 : 3'h0;
					fcs_nxt = {fcs_r[14:0], 1'b0};
					bit_nxt = bit_r + 4'h1;
					if (bit_r == 4'hf) begin
						state_nxt = S_CLOSE;
						sh_nxt = fcs_pkg::FLAG_BYTE;
						bit_nxt = 4'h0;
					end
				end
			end
			S_CLOSE: begin
				val_nxt = 1'b1;
				drv_nxt = 1'b1;
				bit_o_nxt = sh_r[7];
				sh_nxt = {sh_r[6:0], 1'b0};
				bit_nxt = bit_r + 4'h1;
				if (bit_r == 4'h7) begin
					state_nxt = S_IDLE;
					gap_nxt = 20'h00000;
				end
			end
			S_ABORT: begin
				val_nxt = 1'b1;
				drv_nxt = 1'b1;
				bit_o_nxt = 1'b1;                                // [R14]
				bit_nxt = bit_r + 4'h1;
				if (bit_r == 4'(fcs_pkg::ABORT_ONES - 1)) begin
					state_nxt = S_IDLE;
					gap_nxt = 20'h00000;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
		if (TX_ABORT && (state_r == S_DATA || state_r == S_FCS || state_r == S_FLAG)) begin
			state_nxt = S_ABORT;
			ready_nxt = 1'b0;
		end
		// Ones already on the line count toward the abort run [R14]
		if (state_nxt == S_ABORT && state_r != S_ABORT) begin
			bit_nxt = {1'b0, ones_nxt};
		end
		busy_nxt = (state_nxt != S_IDLE) && (state_nxt != S_WAIT);
	end

	// Register stage
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_r <= S_IDLE;
			sh_r <= 8'h00;
			bit_r <= 4'h0;
			flags_r <= 2'h0;
			crc_r <= fcs_pkg::CRC_PRESET;
			fcs_r <= 16'h0000;
			ones_r <= 3'h0;
			cnt_r <= 10'h000;
			last_r <= 1'b0;
			gap_r <= 20'hfffff;
			ready_r <= 1'b0;
			late_r <= 1'b0;
			long_r <= 1'b0;
			bit_o_r <= 1'b1;
			val_r <= 1'b0;
			drv_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
			flags_r <= flags_nxt;
			crc_r <= crc_nxt;
			fcs_r <= fcs_nxt;
			ones_r <= ones_nxt;
			cnt_r <= cnt_nxt;
			last_r <= last_nxt;
			gap_r <= gap_nxt;
			ready_r <= ready_nxt;
			late_r <= late_nxt;
			long_r <= long_nxt;
			bit_o_r <= bit_o_nxt;
			val_r <= val_nxt;
			drv_r <= drv_nxt;
			busy_r <= busy_nxt;
		end
	end
endmodule

// ===== fcs_pkg.sv
/*
 Constants, types and helper functions for the serial link frame check
 and framing logic, shared by the sending and receiving ends.
 Assumes a single 250 MHz clock and one link bit per clock cycle.
*/
// What this block does
// (R1) CRC-16 polynomial x16+x12+x5+1 frames check
// (R2) Sender covers destination through last data bit
// (R3) CRC register preset to all ones
// (R4) Sender transmits inverted final remainder
// (R5) Check field sent power-15 bit first
// (R6) Receiver residue must equal fixed constant
// (R7) Receiver discards frames with wrong residue
// (R8) Types 01 to 7f are client data
// (R9) Type zero is invalid, never sent; the sender does not check the type byte and sends type zero if given it
// (R10) Types 80 to ff are control frames
// (R11) Type 01 short, 02 extended datagram
// (R12) Frames delimited by flag 01111110
// (R13) Sender opens with two or more flags
// (R14) Abort is 12 to 18 ones
// (R15) Data field at most 600 bytes
// (R16) Next frame in dialogue within 200 us
// (R17) Dialogues separated by 400 us idle
// (R18) Extra dialogue deferral in 100 us slots
// (R19) CRC one bit per bit, flags excluded
package fcs_pkg;
	localparam logic [15:0] CRC_POLY      = 16'h1021;   // Feedback taps x12, x5, x0
	localparam logic [15:0] CRC_PRESET    = 16'hffff;   // Register preset value
	localparam logic [15:0] CRC_RESIDUE   = 16'h1d0f;   // Good-frame residue
	localparam logic [7:0]  FLAG_BYTE     = 8'h7e;      // Frame delimiter
	localparam int          OPEN_FLAGS    = 2;          // Least opening flags
	localparam int          ABORT_ONES    = 16;         // Abort length, within 12..18
	localparam int          ABORT_MIN     = 12;         // Shortest abort a peer sends
	localparam int          MAX_DATA      = 600;        // Longest data field, bytes
	localparam int          CLK_MHZ       = 250;        // Clock rate
	localparam int          IFG_US        = 200;        // Inter-frame gap, longest
	localparam int          IDG_US        = 400;        // Inter-dialogue gap, least
	localparam int          SLOT_US       = 100;        // Deferral slot
	localparam int          IFG_CYC       = IFG_US * CLK_MHZ - 1;  // Strictly less than
	localparam int          IDG_CYC       = IDG_US * CLK_MHZ;
	localparam int          SLOT_CYC      = SLOT_US * CLK_MHZ;
	localparam logic [7:0]  TYPE_INVALID  = 8'h00;
	localparam logic [7:0]  TYPE_SHORT    = 8'h01;
	localparam logic [7:0]  TYPE_EXT      = 8'h02;
	localparam logic [7:0]  TYPE_EXPER    = 8'h0f;
	localparam logic [7:0]  TYPE_RSV_TOP  = 8'h0f;
	localparam logic [7:0]  TYPE_CTRL     = 8'h80;
	localparam logic [7:0]  TYPE_ENQ      = 8'h81;
	localparam logic [7:0]  TYPE_ACK      = 8'h82;
	localparam logic [7:0]  TYPE_RTS      = 8'h84;
	localparam logic [7:0]  TYPE_CTS      = 8'h85;

	// Frame type classes reported by the receiver
	typedef enum logic [3:0] {
		FT_INVALID               = 4'h0,
		FT_SHORT_DGRAM           = 4'h1,
		FT_EXT_DGRAM             = 4'h2,
		FT_EXPERIMENTAL          = 4'h3,
		FT_RESERVED_DATA         = 4'h4,
		FT_CLIENT_DATA           = 4'h5,
		FT_ADDRESS_ENQUIRY_FRAME = 4'h6,
		FT_ADDRESS_ACK_FRAME     = 4'h7,
		FT_REQUEST_TO_SEND_FRAME = 4'h8,
		FT_CLEAR_TO_SEND_FRAME   = 4'h9,
		FT_OTHER_CONTROL         = 4'ha
	} frame_type_e;

	// One CRC step, top bit first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);   // [R1] [R19]
	endfunction

	// Classify a type byte
	function automatic frame_type_e classify(input logic [7:0] t);
		frame_type_e r;
		r = FT_INVALID;
		if (t == TYPE_INVALID) begin
			r = FT_INVALID;                          // [R9]
		end else if (t < TYPE_CTRL) begin
			if (t == TYPE_SHORT) r = FT_SHORT_DGRAM;  // [R11]
			else if (t == TYPE_EXT) r = FT_EXT_DGRAM;
			else if (t == TYPE_EXPER) r = FT_EXPERIMENTAL;  // [R8]
			else if (t <= TYPE_RSV_TOP) r = FT_RESERVED_DATA;
			else r = FT_CLIENT_DATA;
		end else begin
			case (t)                                 // [R10]
				TYPE_ENQ: r = FT_ADDRESS_ENQUIRY_FRAME;
				TYPE_ACK: r = FT_ADDRESS_ACK_FRAME;
				TYPE_RTS: r = FT_REQUEST_TO_SEND_FRAME;
				TYPE_CTS: r = FT_CLEAR_TO_SEND_FRAME;
				default:  r = FT_OTHER_CONTROL;
			endcase
		end
		classify = r;
	endfunction
endpackage

// ===== fcs_link_if.sv
/*
 Serial link carrier joining a sending end and a receiving end.
 Assumes both ends share CLK; one bit per clock when bit_valid is high.
*/
`timescale 1ns/100ps
interface fcs_link_if;
	logic bit_data;    // Line bit after stuffing
	logic bit_valid;   // Bit present this cycle
	logic drive_en;    // Sender drives the line

	modport tx_end (output bit_data, output bit_valid, output drive_en);
	modport rx_end (input bit_data, input bit_valid, input drive_en);
endinterface

// ===== fcs_rx.sv
/*
 Receiving end: flag hunt, destuffing, CRC check, type classification.
 Assumes bits arrive one per clock with bit_valid from the carrier.
*/
`timescale 1ns/100ps
module fcs_rx (
	input  wire logic  CLK,
	input  wire logic  RST_N,
	fcs_link_if.rx_end link,
	output logic       RX_VALID,      // Byte pulse
	output logic [7:0] RX_DATA,       // Received byte, check bytes included
	output logic       RX_GOOD,       // Frame end pulse, residue matched
	output logic       RX_BAD,        // Frame end pulse, discard
	output logic       RX_ABORTED,    // Abort seen pulse
	output logic [3:0] RX_TYPE        // Class of the type byte
);
	logic [7:0]  win_r, win_nxt;     // Raw bit window for flag hunt
	logic [7:0]  sh_r, sh_nxt;       // Destuffed byte assembly
	logic [3:0]  bit_r, bit_nxt;
	logic [4:0]  ones_r, ones_nxt;   // Consecutive raw ones
	logic [15:0] crc_r, crc_nxt;
	logic [15:0] crcb_r, crcb_nxt;   // CRC at last byte boundary, skips flag bits
	logic [9:0]  cnt_r, cnt_nxt;     // Bytes in frame
	logic        in_r, in_nxt;       // Inside a frame
	logic        vo_r, vo_nxt;
	logic [7:0]  do_r, do_nxt;
	logic        go_r, go_nxt;
	logic        bo_r, bo_nxt;
	logic        ao_r, ao_nxt;
	logic [3:0]  ty_r, ty_nxt;

	assign RX_VALID = vo_r;
	assign RX_DATA = do_r;
	assign RX_GOOD = go_r;
	assign RX_BAD = bo_r;
	assign RX_ABORTED = ao_r;
	assign RX_TYPE = ty_r;

	// Next-state logic for the receiver
	always_comb begin
		logic       b;
		logic [7:0] w;
		logic [7:0] byte_v;
		b = link.bit_data;
		w = {win_r[6:0], b};
		byte_v = {b, sh_r[7:1]};
		win_nxt = win_r;
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		ones_nxt = ones_r;
		crc_nxt = crc_r;
		crcb_nxt = crcb_r;
		cnt_nxt = cnt_r;
		in_nxt = in_r;
		vo_nxt = 1'b0;
		do_nxt = do_r;
		go_nxt = 1'b0;
		bo_nxt = 1'b0;
		ao_nxt = 1'b0;
		ty_nxt = ty_r;
		if (link.bit_valid) begin
			win_nxt = w;
			ones_nxt = b ? ((ones_r == 5'h1f) ? ones_r : ones_r + 5'h01) : 5'h00;
			if (w == fcs_pkg::FLAG_BYTE) begin               // [R12]
				// Closing flag ends a frame holding at least the check bytes
				if (in_r && cnt_r >= 10'h002) begin
					// Closing flag bits went into crc_r; judge the byte snapshot
					if (crcb_r == fcs_pkg::CRC_RESIDUE) go_nxt = 1'b1;   // [R6]
					else bo_nxt = 1'b1;                         // [R7]
				end
				in_nxt = 1'b1;
				crc_nxt = fcs_pkg::CRC_PRESET;                  // [R3]
				crcb_nxt = fcs_pkg::CRC_PRESET;
				bit_nxt = 4'h0;
				cnt_nxt = 10'h000;
			end else if (ones_r == 5'(fcs_pkg::ABORT_MIN - 1) && b) begin
				if (in_r) ao_nxt = 1'b1;                        // [R14]
				in_nxt = 1'b0;
			end else if (in_r && ones_r == 5'h05 && !b) begin
				// Stuffed zero, dropped
			end else if (in_r) begin
				crc_nxt = fcs_pkg::crc_step(crc_r, b);          // [R6] [R19]
				sh_nxt = byte_v;
				bit_nxt = bit_r + 4'h1;
				if (bit_r == 4'h7) begin
					bit_nxt = 4'h0;
					crcb_nxt = crc_nxt;
					vo_nxt = 1'b1;
					do_nxt = byte_v;
					cnt_nxt = cnt_r + 10'h001;
					if (cnt_r == 10'h002) ty_nxt = fcs_pkg::classify(byte_v); // [R8] [R10]
					// Header three, data up to limit, check two
					if (cnt_r == 10'(fcs_pkg::MAX_DATA + 5)) begin  // [R15]
						in_nxt = 1'b0;
						bo_nxt = 1'b1;
					end
				end
			end
		end
	end

	// Register stage
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			win_r <= 8'h00;
			sh_r <= 8'h00;
			bit_r <= 4'h0;
			ones_r <= 5'h00;
			crc_r <= fcs_pkg::CRC_PRESET;
			crcb_r <= fcs_pkg::CRC_PRESET;
			cnt_r <= 10'h000;
			in_r <= 1'b0;
			vo_r <= 1'b0;
			do_r <= 8'h00;
			go_r <= 1'b0;
			bo_r <= 1'b0;
			ao_r <= 1'b0;
			ty_r <= 4'h0;
		end else begin
			win_r <= win_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
			ones_r <= ones_nxt;
			crc_r <= crc_nxt;
			crcb_r <= crcb_nxt;
			cnt_r <= cnt_nxt;
			in_r <= in_nxt;
			vo_r <= vo_nxt;
			do_r <= do_nxt;
			go_r <= go_nxt;
			bo_r <= bo_nxt;
			ao_r <= ao_nxt;
			ty_r <= ty_nxt;
		end
	end
endmodule

// ===== fcs_link_properties.sv
/*
 Wire checks on the serial link between the sending and receiving end.
 Assumes one clock CLK and the synchronous active-low reset RST_N.
*/
`timescale 1ns/100ps
module fcs_link_properties (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic bit_data,
	input wire logic bit_valid,
	input wire logic drive_en
);
	logic [7:0] run_r;   // Consecutive ones seen on the line
	logic [7:0] run_nxt;
	logic [7:0] sh_r;    // Last eight line bits
	logic [7:0] sh_nxt;

	// Count runs of ones and keep the recent bits
	always_comb begin
		run_nxt = (bit_valid && bit_data && run_r != 8'hff) ? run_r + 8'h01 : 8'h00;
		sh_nxt = bit_valid ? {sh_r[6:0], bit_data} : sh_r;
	end
	always_ff @(posedge CLK) begin
		run_r <= RST_N ? run_nxt : 8'h00;
		sh_r <= RST_N ? sh_nxt : 8'h00;
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// One delimiter byte on the line
	sequence flag_s;
		!bit_data ##1 bit_data [*6] ##1 !bit_data;
	endsequence

	a_opening_two_flags: assert property ($rose(bit_valid) |-> flag_s ##1 flag_s)
		else $error("frame does not open with two flags");
	a_closing_flag: assert property ($fell(bit_valid) |-> sh_r == 8'h7e || run_r >= 8'h0c)
		else $error("frame ends without flag or abort");
	a_abort_length: assert property ((run_r > 8'h06 && !(bit_valid && bit_data))
		|-> run_r >= 8'h0c && run_r <= 8'h12)
		else $error("abort run outside 12 to 18 ones");
	a_run_bounded: assert property (bit_valid && bit_data |-> run_r < 8'h12)
		else $error("run of ones longer than 18");
	a_valid_driven: assert property (bit_valid |-> drive_en)
		else $error("bit offered while line not driven");
	a_idle_ones: assert property (!drive_en |-> bit_data)
		else $error("idle line not high");
	a_release_bound: assert property ($fell(bit_valid) |-> ##[0:40] !drive_en)
		else $error("line not released after frame");
	a_drive_start: assert property ($rose(drive_en) |-> ##[0:4] bit_valid)
		else $error("driver on without bits");
endmodule

// ===== link_frame_fcs_and_framing_test.sv
/*
 Testbench: a sending end feeds a receiving end; a second receiver takes
 hand-made frames. Assumes fcs_pkg and one bit per clock on the link.
*/
`timescale 1ns/100ps
module link_frame_fcs_and_framing_test;
	logic       CLK = 1'b0, RST_N = 1'b0, TX_START = 1'b0, TX_VALID = 1'b0;
	logic       TX_LAST = 1'b0, TX_ABORT = 1'b0, TX_NEW_DIALOGUE = 1'b0;
	logic [3:0] TX_DEFER_SLOTS = 4'h0;
	logic [7:0] TX_DATA = 8'h00;
	logic       TX_READY, TX_BUSY, TX_GAP_LATE, TX_TOO_LONG;
	logic       RX_VALID, RX_GOOD, RX_BAD, RX_ABORTED, B_GOOD, B_BAD;
	logic [7:0] RX_DATA;
	logic [3:0] RX_TYPE, B_TYPE;
	logic [7:0] fr [0:609];    // Frame bytes under test
	logic [7:0] rx_q [$];      // Bytes delivered by the receiver
	int         checks = 0, mismatches = 0, cyc = 0, ones = 0;
	int         good_n = 0, bad_n = 0, abort_n = 0, bgood_n = 0, bbad_n = 0;
	logic [7:0] ty_t [10] = '{8'h01, 8'h02, 8'h0f, 8'h05, 8'h7f,
		8'h81, 8'h82, 8'h84, 8'h85, 8'h80};
	logic [3:0] cl_t [10] = '{fcs_pkg::FT_SHORT_DGRAM, fcs_pkg::FT_EXT_DGRAM,
		fcs_pkg::FT_EXPERIMENTAL, fcs_pkg::FT_RESERVED_DATA, fcs_pkg::FT_CLIENT_DATA,
		fcs_pkg::FT_ADDRESS_ENQUIRY_FRAME, fcs_pkg::FT_ADDRESS_ACK_FRAME,
		fcs_pkg::FT_REQUEST_TO_SEND_FRAME, fcs_pkg::FT_CLEAR_TO_SEND_FRAME,
		fcs_pkg::FT_OTHER_CONTROL};

	fcs_link_if fcs_link_if_i ();
	fcs_link_if bad_link_i ();    // Line driven by the bench
	fcs_tx fcs_tx_i (.CLK(CLK), .RST_N(RST_N), .TX_START(TX_START),
		.TX_NEW_DIALOGUE(TX_NEW_DIALOGUE), .TX_DEFER_SLOTS(TX_DEFER_SLOTS),
		.TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_ABORT(TX_ABORT),
		.TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .TX_GAP_LATE(TX_GAP_LATE),
		.TX_TOO_LONG(TX_TOO_LONG), .link(fcs_link_if_i));
	fcs_rx fcs_rx_i (.CLK(CLK), .RST_N(RST_N), .link(fcs_link_if_i), .RX_VALID(RX_VALID),
		.RX_DATA(RX_DATA), .RX_GOOD(RX_GOOD), .RX_BAD(RX_BAD),
		.RX_ABORTED(RX_ABORTED), .RX_TYPE(RX_TYPE));
	fcs_rx fcs_rx_bad_i (.CLK(CLK), .RST_N(RST_N), .link(bad_link_i), .RX_VALID(),
		.RX_DATA(), .RX_GOOD(B_GOOD), .RX_BAD(B_BAD), .RX_ABORTED(), .RX_TYPE(B_TYPE));
	fcs_link_properties fcs_link_properties_i (.CLK(CLK), .RST_N(RST_N),
		.bit_data(fcs_link_if_i.bit_data), .bit_valid(fcs_link_if_i.bit_valid),
		.drive_en(fcs_link_if_i.drive_en));

	always #2 CLK = ~CLK;

	// Collect receiver output, count pulses, cut a hang short
	always @(posedge CLK) begin
		if (RX_VALID === 1'b1)
			rx_q.push_back(RX_DATA);
		good_n += int'(RX_GOOD === 1'b1);
		bad_n += int'(RX_BAD === 1'b1);
		abort_n += int'(RX_ABORTED === 1'b1);
		bgood_n += int'(B_GOOD === 1'b1);
		bbad_n += int'(B_BAD === 1'b1);
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected check field over the first n bytes, line order LSB first
	function automatic logic [15:0] crc_of(input int n);
		logic [15:0] c;
		c = fcs_pkg::CRC_PRESET;
		for (int i = 0; i < n; i++)
			for (int j = 0; j < 8; j++)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[i][j]) ? fcs_pkg::CRC_POLY : 16'h0000);
		return ~c;
	endfunction

	task automatic build(input int n, input logic [7:0] ty);
		for (int i = 0; i < n; i++)
			fr[i] = 8'(i * 37 + 60);
		fr[0] = 8'h0a;
		fr[1] = 8'h05;
		fr[2] = ty;
		fr[3] = 8'hff;    // Forces a stuffed bit
	endtask

	// Offer n bytes; after byte cut, drop the data and abort
	task automatic send(input int n, input int cut);
		int t;
		int s;
		rx_q.delete();
		s = good_n + bad_n + abort_n;
		TX_START <= 1'b1;
		for (int i = 0; i < n; i++) begin
			TX_VALID <= 1'b1;
			TX_DATA <= fr[i];
			TX_LAST <= (i == n - 1);
			t = 0;
			do begin
				@(posedge CLK);
				t++;
			end while (TX_READY !== 1'b1 && TX_TOO_LONG !== 1'b1 && t < 300);
			TX_START <= 1'b0;
			if (i == cut || TX_TOO_LONG === 1'b1)
				break;
		end
		TX_VALID <= 1'b0;
		TX_LAST <= 1'b0;
		TX_ABORT <= (cut < n);
		repeat (3) @(posedge CLK);
		TX_ABORT <= 1'b0;
		t = 0;
		while (good_n + bad_n + abort_n == s && t < 9000) begin
			@(posedge CLK);
			t++;
		end
		repeat (20) @(posedge CLK);
	endtask

	task automatic good_frame(input int n, input logic [7:0] ty, input logic [3:0] cls);
		logic [15:0] r;
		int g;
		build(n, ty);
		r = {<<{crc_of(n)}};
		g = good_n;
		send(n, n);
		cmp(16'(good_n - g), 16'h0001);
		cmp(16'(rx_q.size()), 16'(n + 2));
		cmp({15'h0000, TX_BUSY}, 16'h0000);
		for (int i = 0; i < n; i++)
			cmp({8'h00, rx_q[i]}, {8'h00, fr[i]});
		cmp({rx_q[n + 1], rx_q[n]}, r);
		cmp({12'h000, RX_TYPE}, {12'h000, cls});
	endtask

	// One line bit on the bench-driven link, stuffing after five ones
	task automatic put_bit(input logic b, input logic st);
		bad_link_i.bit_data <= b;
		bad_link_i.bit_valid <= 1'b1;
		bad_link_i.drive_en <= 1'b1;
		@(posedge CLK);
		ones = (b && st) ? ones + 1 : 0;
		if (ones == 5) begin
			ones = 0;
			bad_link_i.bit_data <= 1'b0;
			@(posedge CLK);
		end
	endtask

	task automatic inject(input int n, input logic flip);
		logic [15:0] f;
		int t;
		int s;
		f = crc_of(n) ^ {15'h0000, flip};
		s = bgood_n + bbad_n;
		for (int k = 0; k < 16; k++)
			put_bit(k % 8 != 0 && k % 8 != 7, 1'b0);
		for (int i = 0; i < n * 8; i++)
			put_bit(fr[i / 8][i % 8], 1'b1);
		for (int j = 15; j >= 0; j--)
			put_bit(f[j], 1'b1);
		for (int k = 0; k < 8; k++)
			put_bit(k != 0 && k != 7, 1'b0);
		bad_link_i.bit_valid <= 1'b0;
		bad_link_i.drive_en <= 1'b0;
		bad_link_i.bit_data <= 1'b1;
		t = 0;
		while (bgood_n + bbad_n == s && t < 200) begin
			@(posedge CLK);
			t++;
		end
	endtask

	// Main sequence
	initial begin
		int g;
		int h;
		bad_link_i.bit_data = 1'b1;
		bad_link_i.bit_valid = 1'b0;
		bad_link_i.drive_en = 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		for (int k = 0; k < 10; k++)
			good_frame(6, ty_t[k], cl_t[k]);
		cmp({15'h0000, TX_GAP_LATE}, 16'h0000);
		build(12, 8'h01);
		g = abort_n;
		h = good_n;
		send(12, 4);
		cmp(16'(abort_n - g), 16'h0001);
		cmp(16'(good_n - h), 16'h0000);
		build(8, 8'h81);
		g = bgood_n;
		inject(8, 1'b1);
		cmp(16'(bbad_n), 16'h0001);
		cmp(16'(bgood_n - g), 16'h0000);
		build(8, 8'h00);
		inject(8, 1'b0);
		cmp({12'h000, B_TYPE}, {12'h000, fcs_pkg::FT_INVALID});
		cmp(16'(bgood_n - g), 16'h0001);
		good_frame(603, 8'h02, fcs_pkg::FT_EXT_DGRAM);
		cmp({15'h0000, TX_TOO_LONG}, 16'h0000);
		build(604, 8'h02);
		h = good_n;
		send(604, 604);
		cmp({15'h0000, TX_TOO_LONG}, 16'h0001);
		cmp(16'(good_n - h), 16'h0000);
		end_of_test();
	end
endmodule
